/* File: dcp_cmd_edge.v */
// Holds the host-written command bits and pulses each 0->1 transition
`include "dcp_param_regs.vh"
module dcp_cmd_edge (
	input  wire                           clk_sys,
	input  wire                           resetn,
	input  wire                           wr_stb,
	input  wire [`DCP_RUN_CMD_WIDTH-1:0]  wr_bits,
	output reg  [`DCP_RUN_CMD_WIDTH-1:0]  cmd_bits,
	output reg  [`DCP_RUN_CMD_WIDTH-1:0]  cmd_pulse
);

	genvar i;

	generate
		for (i = 0; i < `DCP_RUN_CMD_WIDTH; i = i + 1) begin : g_bit
			always @(posedge clk_sys or negedge resetn) begin
				if (!resetn) begin
					cmd_bits[i]  <= 1'b0;
					cmd_pulse[i] <= 1'b0;
				end else begin
					// Only a rising transition acts; holding the bit at one repeats nothing
					cmd_pulse[i] <= wr_stb & wr_bits[i] & ~cmd_bits[i]; // RQ4 RQ5
					if (wr_stb) begin
						cmd_bits[i] <= wr_bits[i];
					end
				end
			end
		end
	endgenerate

endmodule // dcp_cmd_edge

/* File: dcp_host_model.sv */
module dcp_host_model (
	input  logic        clk_sys,
	input  logic        host_ack,
	input  logic [15:0] host_rdata,
	output logic [15:0] host_addr,
	output logic        host_rd,
	output logic        host_wr,
	output logic [15:0] host_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		host_addr = 16'h0000;
		host_rd = 1'b0;
		host_wr = 1'b0;
		host_wdata = 16'h0000;
	end
	// Strobe lasts one edge only: a held strobe would be taken as a second request
	task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] d, output logic [15:0] q,
			output logic ok);
		@(posedge clk_sys);
		#1;
		host_addr = a;
		host_wdata = d;
		host_wr = wr;
		host_rd = !wr;
		@(posedge clk_sys);
		#1;
		host_rd = 1'b0;
		host_wr = 1'b0;
		host_addr = ~a;
		host_wdata = ~d;
		ok = host_ack;
		q = host_rdata;
	endtask
endmodule // dcp_host_model

/* File: dcp_param_map.v */
// What this block does
// RQ1 - Common words sit at fixed addresses for every power rating.
// RQ2 - Capacity word reports rating code, FFFF smallest up to 000B largest.
// RQ3 - Frequency setpoint in 0.01 Hz steps, clamped between start and maximum.
// RQ4 - Rising write on run bits 0,1,2 requests stop, forward, reverse; readable.
// RQ5 - Rising write on bit 3 resets fault, bit 4 emergency stop; write-only.
// RQ6 - Run word bits 6-7 report active run command source.
// RQ7 - Run word bits 8-12 report active frequency command source code.
// RQ8 - Ramp up and ramp down times are read/write, 0.1 second units.
// RQ9 - State word bits 0-2 stopped/forward/reverse, bit 8 stopping.
// RQ10 - State bits 11-12 latched run commands, 13-14 remote control flags.
// RQ11 - Fault word has one bit per trip cause, bit 5 ground fault.
// RQ12 - Fault bit 11 nonvolatile write error, bit 15 undervoltage trip.
// RQ13 - Written values act at once and return to defaults on reset.
// RQ14 - Firmware version word is presented in hexadecimal form.
// RQ15 - Unused or reserved bits read zero and ignore writes.
`include "dcp_param_regs.vh"

module dcp_param_map (
	input  wire        clk_sys,
	input  wire        resetn,
	// Host word access
	input  wire [15:0] host_addr,
	input  wire        host_rd,
	input  wire        host_wr,
	input  wire [15:0] host_wdata,
	output reg  [15:0] host_rdata,
	output reg         host_ack,
	output reg         host_err_addr,
	output reg         host_err_write,
	output reg         host_err_data,
	// Drive controller identity and settings
	input  wire [15:0] power_rating_code,
	input  wire        supply_class,
	input  wire        param_unlocked,
	input  wire [15:0] freq_command_raw,
	input  wire [15:0] start_frequency,
	input  wire [15:0] max_frequency,
	input  wire [1:0]  run_source,
	input  wire [4:0]  freq_source,
	// Drive controller measurements and state
	input  wire [15:0] output_current_meas,
	input  wire [15:0] output_frequency_meas,
	input  wire        running_fwd,
	input  wire        running_rev,
	input  wire        drive_tripped,
	input  wire        accelerating,
	input  wire        decelerating,
	input  wire        speed_arrival,
	input  wire        dc_braking,
	input  wire        stopping,
	input  wire        brake_open,
	// Trip causes from the drive controller
	input  wire        overcurrent_trip,
	input  wire        overvoltage_trip,
	input  wire        external_trip_a,
	input  wire        output_block_trip,
	input  wire        current_limit_trip,
	input  wire        ground_fault_trip,
	input  wire        heatsink_overheat_trip,
	input  wire        motor_thermal_trip,
	input  wire        overload_trip,
	input  wire        hardware_diagnostic_trip,
	input  wire        external_trip_b,
	input  wire        nonvolatile_write_error,
	input  wire        cooling_fan_error,
	input  wire        phase_loss_trip,
	input  wire        drive_overload_trip,
	input  wire        undervoltage_trip,
	// Input terminal pins, asynchronous
	input  wire [7:0]  input_pins,
	// Commands toward the drive controller
	output wire        stop_req,
	output wire        fwd_run_req,
	output wire        rev_run_req,
	output wire        fault_reset_req,
	output wire        estop_req,
	output reg  [15:0] ramp_up_time,
	output reg  [15:0] ramp_down_time,
	output reg  [15:0] frequency_setpoint
);

	wire [`DCP_RUN_CMD_WIDTH-1:0] cmd_bits;
	wire [`DCP_RUN_CMD_WIDTH-1:0] cmd_pulse;
	reg  [7:0]                    pins_meta;
	reg  [7:0]                    input_pin_state;
	reg                           latched_fwd;
	reg                           latched_rev;
	reg  [15:0]                   read_word;
	reg                           addr_known;
	reg                           addr_writable;
	reg                           data_ok;
	wire                          wr_go;
	wire                          run_wr_stb;
	wire                          remote_run_stop_flag;
	wire                          remote_frequency_flag;
	wire [15:0]                   run_control_word;
	wire [15:0]                   drive_state_word;
	wire [15:0]                   fault_cause_flags;
	wire [15:0]                   supply_class_word;
	wire [15:0]                   param_lock_word;
	wire [15:0]                   input_pin_word;
	wire                          host_req;
	wire                          wr_ramp_up;
	wire                          wr_ramp_down;

	// Pins come from outside the clock domain
	// Only the second stage is read, so a metastable first stage never reaches the decode
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pins_meta       <= 8'h00;
			input_pin_state <= 8'h00;
		end else begin
			pins_meta       <= input_pins;
			input_pin_state <= pins_meta;
		end
	end

	// Clamp the commanded frequency; if the limits cross, a command above the maximum gets the maximum, any other the start
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			frequency_setpoint <= 16'h0000;
		end else if (freq_command_raw > max_frequency) begin
			frequency_setpoint <= max_frequency; // RQ3
		end else if (freq_command_raw < start_frequency) begin
			frequency_setpoint <= start_frequency; // RQ3
		end else begin
			frequency_setpoint <= freq_command_raw; // RQ3
		end
	end

	// A refused write, by address or by range, changes no setting or command; only the ack, the read data and the error flags respond
	assign host_req     = host_rd | host_wr;
	assign wr_go        = host_wr & addr_writable & data_ok;
	assign run_wr_stb   = wr_go & (host_addr == `DCP_ADDR_RUN_CONTROL);
	assign wr_ramp_up   = wr_go & (host_addr == `DCP_ADDR_RAMP_UP);
	assign wr_ramp_down = wr_go & (host_addr == `DCP_ADDR_RAMP_DOWN);

	// Stored bits let a repeated write of the same value pass without a second request
	dcp_cmd_edge u_cmd_edge (
		.clk_sys   (clk_sys),
		.resetn    (resetn),
		.wr_stb    (run_wr_stb),
		.wr_bits   (host_wdata[`DCP_RUN_CMD_WIDTH-1:0]),
		.cmd_bits  (cmd_bits),
		.cmd_pulse (cmd_pulse)
	);

	// Each request stands one cycle; the drive controller must act on it then
	assign stop_req        = cmd_pulse[`DCP_RUN_STOP_BIT]; // RQ4
	assign fwd_run_req     = cmd_pulse[`DCP_RUN_FWD_BIT]; // RQ4
	assign rev_run_req     = cmd_pulse[`DCP_RUN_REV_BIT]; // RQ4
	assign fault_reset_req = cmd_pulse[`DCP_RUN_FRESET_BIT]; // RQ5
	assign estop_req       = cmd_pulse[`DCP_RUN_ESTOP_BIT]; // RQ5

	// Stop and emergency stop take priority so a write that raises either along with a run bit never leaves a run latched
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			latched_fwd <= 1'b0;
			latched_rev <= 1'b0;
		end else if (stop_req | estop_req) begin
			latched_fwd <= 1'b0; // RQ10
			latched_rev <= 1'b0; // RQ10
		end else if (fwd_run_req) begin
			latched_fwd <= 1'b1; // RQ10
			latched_rev <= 1'b0;
		end else if (rev_run_req) begin
			latched_fwd <= 1'b0;
			latched_rev <= 1'b1; // RQ10
		end
	end

	// Ramp times revert to defaults on any reset
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ramp_up_time   <= `DCP_RESET_RAMP_UP; // RQ13
			ramp_down_time <= `DCP_RESET_RAMP_DOWN; // RQ13
		end else begin
			if (wr_ramp_up) begin
				ramp_up_time <= host_wdata; // RQ8
			end
			if (wr_ramp_down) begin
				ramp_down_time <= host_wdata; // RQ8
			end
		end
	end

	// Remote means the serial link owns the source, not the keypad or the terminals
	assign remote_run_stop_flag  = (run_source == `DCP_RUN_SRC_SERIAL);
	assign remote_frequency_flag = (freq_source == `DCP_FREQ_SRC_SERIAL);

	// Bits 3-4 are write-only, bits 5 and 13-15 unused: all read zero
	assign run_control_word[`DCP_RUN_REV_BIT:`DCP_RUN_STOP_BIT] = cmd_bits[`DCP_RUN_REV_BIT:`DCP_RUN_STOP_BIT]; // RQ4
	assign run_control_word[5:3] = 3'h0; // RQ5 RQ15
	assign run_control_word[`DCP_RUN_SRC_MSB:`DCP_RUN_SRC_LSB] = run_source; // RQ6
	assign run_control_word[`DCP_FREQ_SRC_MSB:`DCP_FREQ_SRC_LSB] = freq_source; // RQ7
	assign run_control_word[15:13] = 3'h0; // RQ15

	// State word; bits 9 and 15 carry nothing
	assign drive_state_word[0]                        = ~(running_fwd | running_rev); // RQ9
	assign drive_state_word[1]                        = running_fwd; // RQ9
	assign drive_state_word[2]                        = running_rev; // RQ9
	assign drive_state_word[3]                        = drive_tripped;
	assign drive_state_word[4]                        = accelerating;
	assign drive_state_word[5]                        = decelerating;
	assign drive_state_word[6]                        = speed_arrival;
	assign drive_state_word[7]                        = dc_braking;
	assign drive_state_word[8]                        = stopping; // RQ9
	assign drive_state_word[9]                        = 1'b0; // RQ15
	assign drive_state_word[10]                       = brake_open;
	assign drive_state_word[`DCP_STATE_LATCH_FWD_BIT] = latched_fwd; // RQ10
	assign drive_state_word[`DCP_STATE_LATCH_REV_BIT] = latched_rev; // RQ10
	assign drive_state_word[13]                       = remote_run_stop_flag; // RQ10
	assign drive_state_word[14]                       = remote_frequency_flag; // RQ10
	assign drive_state_word[15]                       = 1'b0; // RQ15

	// One bit per trip cause, passed as the drive controller reports it
	assign fault_cause_flags[0]                        = overcurrent_trip; // RQ11
	assign fault_cause_flags[1]                        = overvoltage_trip; // RQ11
	assign fault_cause_flags[2]                        = external_trip_a; // RQ11
	assign fault_cause_flags[3]                        = output_block_trip;
	assign fault_cause_flags[4]                        = current_limit_trip;
	assign fault_cause_flags[`DCP_FAULT_GROUND_BIT]    = ground_fault_trip; // RQ11
	assign fault_cause_flags[6]                        = heatsink_overheat_trip; // RQ11
	assign fault_cause_flags[7]                        = motor_thermal_trip;
	assign fault_cause_flags[8]                        = overload_trip; // RQ11
	assign fault_cause_flags[9]                        = hardware_diagnostic_trip;
	assign fault_cause_flags[10]                       = external_trip_b; // RQ11
	assign fault_cause_flags[`DCP_FAULT_NV_WRITE_BIT]  = nonvolatile_write_error; // RQ12
	assign fault_cause_flags[12]                       = cooling_fan_error;
	assign fault_cause_flags[13]                       = phase_loss_trip;
	assign fault_cause_flags[14]                       = drive_overload_trip;
	assign fault_cause_flags[`DCP_FAULT_UNDERVOLT_BIT] = undervoltage_trip; // RQ12

	// Only the low bits of these words carry information
	assign supply_class_word[15:1] = 15'h0000; // RQ15
	assign supply_class_word[0]    = supply_class;

	assign param_lock_word[15:1]   = 15'h0000; // RQ15
	assign param_lock_word[0]      = param_unlocked;

	assign input_pin_word[15:8]    = 8'h00; // RQ15
	assign input_pin_word[7:0]     = input_pin_state;

	// Address decode; the map is the same whatever rating is strapped
	always @* begin
		read_word     = 16'h0000;
		addr_known    = 1'b1;
		addr_writable = 1'b0;
		data_ok       = 1'b1;
		if (host_addr == `DCP_ADDR_POWER_RATING) begin // RQ1
			read_word = power_rating_code; // RQ2
		end else if (host_addr == `DCP_ADDR_SUPPLY_CLASS) begin
			read_word = supply_class_word;
		end else if (host_addr == `DCP_ADDR_FW_VERSION) begin
			read_word = `DCP_FW_VERSION_CODE; // RQ14
		end else if (host_addr == `DCP_ADDR_PARAM_LOCK) begin
			read_word = param_lock_word;
		end else if (host_addr == `DCP_ADDR_FREQ_SETPOINT) begin
			read_word = frequency_setpoint; // RQ3
		end else if (host_addr == `DCP_ADDR_RUN_CONTROL) begin
			read_word     = run_control_word;
			addr_writable = 1'b1; // RQ4 RQ5
		end else if (host_addr == `DCP_ADDR_RAMP_UP) begin
			// Only the ramp words are range checked; an out-of-range time leaves the old one
			read_word     = ramp_up_time; // RQ8
			addr_writable = 1'b1;
			data_ok       = (host_wdata <= `DCP_RAMP_MAX);
		end else if (host_addr == `DCP_ADDR_RAMP_DOWN) begin
			read_word     = ramp_down_time; // RQ8
			addr_writable = 1'b1;
			data_ok       = (host_wdata <= `DCP_RAMP_MAX);
		end else if (host_addr == `DCP_ADDR_OUT_CURRENT) begin
			read_word = output_current_meas;
		end else if (host_addr == `DCP_ADDR_OUT_FREQUENCY) begin
			read_word = output_frequency_meas;
		end else if (host_addr == `DCP_ADDR_DRIVE_STATE) begin
			read_word = drive_state_word; // RQ9
		end else if (host_addr == `DCP_ADDR_FAULT_CAUSE) begin
			read_word = fault_cause_flags; // RQ11
		end else if (host_addr == `DCP_ADDR_INPUT_PINS) begin
			read_word = input_pin_word; // RQ15
		end else begin
			addr_known = 1'b0;
		end
	end

	// Answer one cycle after the request; a write returns the word as it was before
	// Refused requests are answered too, so the host never waits for a reply that is lost
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			host_rdata     <= 16'h0000;
			host_ack       <= 1'b0;
			host_err_addr  <= 1'b0;
			host_err_write <= 1'b0;
			host_err_data  <= 1'b0;
		end else begin
			host_ack       <= host_req;
			host_rdata     <= (addr_known & host_req) ? read_word : 16'h0000;
			host_err_addr  <= host_req & ~addr_known;
			host_err_write <= host_wr & addr_known & ~addr_writable;
			host_err_data  <= host_wr & addr_writable & ~data_ok;
		end
	end

endmodule // dcp_param_map

/* File: dcp_param_map_bench.sv */
`include "dcp_param_regs.vh"
module dcp_param_map_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic [15:0] host_addr, host_wdata, host_rdata, ramp_up_time, ramp_down_time, frequency_setpoint;
	logic        host_rd, host_wr, host_ack, host_err_addr, host_err_write, host_err_data;
	logic        stop_req, fwd_run_req, rev_run_req, fault_reset_req, estop_req;
	logic [15:0] power_rating_code = 16'hFFFF, freq_command_raw = 16'h9000, start_frequency = 16'h01F4;
	logic [15:0] max_frequency = 16'h1388, output_current_meas = 16'h0123, output_frequency_meas = 16'h0456;
	logic        supply_class = 1'b1, param_unlocked = 1'b0, running_fwd = 1'b0, running_rev = 1'b0, stopping = 1'b0;
	logic [1:0]  run_source = 2'h3;
	logic [4:0]  freq_source = 5'h13;
	logic [7:0]  input_pins = 8'hA5;
	logic [15:0] trips = 16'h8820;
	logic [5:0]  misc = 6'h3F;
	int          err_total = 0;
	int          compares = 0;
	always #25 clk_sys = ~clk_sys;
	dcp_host_model i_dcp_host_model (.clk_sys, .host_ack, .host_rdata, .host_addr, .host_rd, .host_wr, .host_wdata);
	dcp_param_map i_dcp_param_map (.clk_sys, .resetn, .host_addr, .host_rd, .host_wr, .host_wdata, .host_rdata,
		.host_ack, .host_err_addr, .host_err_write, .host_err_data, .power_rating_code, .supply_class, .param_unlocked,
		.freq_command_raw, .start_frequency, .max_frequency, .run_source, .freq_source, .output_current_meas,
		.output_frequency_meas, .running_fwd, .running_rev, .drive_tripped(misc[0]), .accelerating(misc[1]),
		.decelerating(misc[2]), .speed_arrival(misc[3]), .dc_braking(misc[4]), .stopping, .brake_open(misc[5]),
		.overcurrent_trip(trips[0]), .overvoltage_trip(trips[1]), .external_trip_a(trips[2]),
		.output_block_trip(trips[3]), .current_limit_trip(trips[4]), .ground_fault_trip(trips[5]),
		.heatsink_overheat_trip(trips[6]), .motor_thermal_trip(trips[7]), .overload_trip(trips[8]),
		.hardware_diagnostic_trip(trips[9]), .external_trip_b(trips[10]), .nonvolatile_write_error(trips[11]),
		.cooling_fan_error(trips[12]), .phase_loss_trip(trips[13]), .drive_overload_trip(trips[14]),
		.undervoltage_trip(trips[15]), .input_pins, .stop_req, .fwd_run_req, .rev_run_req, .fault_reset_req,
		.estop_req, .ramp_up_time, .ramp_down_time, .frequency_setpoint);
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, s);
			err_total++;
		end
	endtask
	// Every access also proves the absence of stray error flags and command pulses
	task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic [15:0] e,
			input logic [2:0] f, input logic [4:0] p, input string n);
		logic [15:0] q;
		logic        ok;
		i_dcp_host_model.xfer(wr, a, d, q, ok);
		chk("ack", {15'h0000, ok}, 16'h0001);
		chk(n, q, e);
		chk("flags", {13'h0000, host_err_addr, host_err_write, host_err_data}, {13'h0000, f});
		chk("pulses", {11'h000, stop_req, fwd_run_req, rev_run_req, fault_reset_req, estop_req}, {11'h000, p});
	endtask
	task automatic close_out;
		$display("mismatches %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#1000000;
		err_total++;
		close_out;
	end
	initial begin
		repeat (8) @(posedge clk_sys);
		#1 resetn = 1'b1;
		acc(1'b0, 16'h0000, 16'h0000, 16'hFFFF, 3'h0, 5'h00, "rating");
		acc(1'b0, 16'h0001, 16'h0000, 16'h0001, 3'h0, 5'h00, "supply");
		acc(1'b0, 16'h0002, 16'h0000, `DCP_FW_VERSION_CODE, 3'h0, 5'h00, "version");
		acc(1'b0, 16'h0006, 16'h0000, 16'h0032, 3'h0, 5'h00, "ramp_up");
		acc(1'b0, 16'h0007, 16'h0000, 16'h0064, 3'h0, 5'h00, "ramp_down");
		acc(1'b0, 16'h0008, 16'h0000, 16'h0123, 3'h0, 5'h00, "current");
		acc(1'b0, 16'h000F, 16'h0000, 16'h00A5, 3'h0, 5'h00, "pins");
		acc(1'b0, 16'h0004, 16'h0000, 16'h1388, 3'h0, 5'h00, "setpoint_hi");
		freq_command_raw = 16'h0010;
		acc(1'b0, 16'h0004, 16'h0000, 16'h01F4, 3'h0, 5'h00, "setpoint_lo");
		chk("setpoint_port", frequency_setpoint, 16'h01F4);
		acc(1'b0, 16'h0009, 16'h0000, 16'h0456, 3'h0, 5'h00, "out_freq");
		acc(1'b0, 16'h000E, 16'h0000, 16'h8820, 3'h0, 5'h00, "faults");
		acc(1'b0, 16'h000B, 16'h0000, 16'h0000, 3'h4, 5'h00, "unmapped");
		acc(1'b1, 16'h0000, 16'h0001, 16'hFFFF, 3'h2, 5'h00, "ro_write");
		acc(1'b1, 16'h0006, 16'hEA61, 16'h0032, 3'h1, 5'h00, "range");
		acc(1'b1, 16'h0006, 16'hEA60, 16'h0032, 3'h0, 5'h00, "ramp_wr");
		acc(1'b0, 16'h0006, 16'h0000, 16'hEA60, 3'h0, 5'h00, "ramp_rd");
		acc(1'b1, 16'h0007, 16'h0005, 16'h0064, 3'h0, 5'h00, "ramp_dn_wr");
		acc(1'b0, 16'h0007, 16'h0000, 16'h0005, 3'h0, 5'h00, "ramp_dn_rd");
		chk("ramp_up_port", ramp_up_time, 16'hEA60);
		chk("ramp_dn_port", ramp_down_time, 16'h0005);
		acc(1'b1, 16'h0005, 16'hFFE0, 16'h13C0, 3'h0, 5'h00, "reserved");
		acc(1'b0, 16'h0005, 16'h0000, 16'h13C0, 3'h0, 5'h00, "run_src");
		acc(1'b1, 16'h0005, 16'h0002, 16'h13C0, 3'h0, 5'h08, "fwd");
		acc(1'b0, 16'h000D, 16'h0000, 16'h6CF9, 3'h0, 5'h00, "state_fwd");
		acc(1'b1, 16'h0005, 16'h0002, 16'h13C2, 3'h0, 5'h00, "no_repeat");
		acc(1'b1, 16'h0005, 16'h001A, 16'h13C2, 3'h0, 5'h03, "fault_estop");
		acc(1'b0, 16'h0005, 16'h0000, 16'h13C2, 3'h0, 5'h00, "wo_bits");
		acc(1'b0, 16'h000D, 16'h0000, 16'h64F9, 3'h0, 5'h00, "state_clr");
		misc = 6'h00;
		running_rev = 1'b1;
		stopping = 1'b1;
		acc(1'b1, 16'h0005, 16'h0004, 16'h13C2, 3'h0, 5'h04, "rev");
		acc(1'b0, 16'h000D, 16'h0000, 16'h7104, 3'h0, 5'h00, "state_rev");
		acc(1'b1, 16'h0005, 16'h0001, 16'h13C4, 3'h0, 5'h10, "stop");
		for (int i = 0; i < 4; i++) begin
			run_source = 2'(i);
			freq_source = 5'(i * 7);
			param_unlocked = 1'(i);
			trips = 16'(16'h1111 << i);
			acc(1'b0, 16'h0005, 16'h0000, {3'h0, 5'(i * 7), 2'(i), 6'h01}, 3'h0, 5'h00, "sources");
			acc(1'b0, 16'h0003, 16'h0000, 16'(i & 1), 3'h0, 5'h00, "lock");
			acc(1'b0, 16'h000E, 16'h0000, 16'(16'h1111 << i), 3'h0, 5'h00, "trip_bits");
		end
		resetn = 1'b0;
		@(posedge clk_sys);
		#1 resetn = 1'b1;
		acc(1'b0, 16'h0006, 16'h0000, 16'h0032, 3'h0, 5'h00, "ramp_after_reset");
		chk("ramp_dn_reset", ramp_down_time, 16'h0064);
		acc(1'b0, 16'h0005, 16'h0000, 16'h15C0, 3'h0, 5'h00, "run_after_reset");
		close_out;
	end
endmodule // dcp_param_map_bench

/* File: dcp_param_map_props.sv */
module dcp_param_map_props (
	input logic        clk_sys,
	input logic        resetn,
	input logic [15:0] host_addr,
	input logic        host_rd,
	input logic        host_wr,
	input logic [15:0] host_wdata,
	input logic        host_ack,
	input logic        host_err_addr,
	input logic        fwd_run_req,
	input logic        fault_reset_req,
	input logic        estop_req,
	input logic [15:0] ramp_up_time,
	input logic [15:0] start_frequency,
	input logic [15:0] max_frequency,
	input logic [15:0] frequency_setpoint
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	wire logic wr_run = host_wr && host_addr == 16'h0005;
	wire logic wr_up = host_wr && host_addr == 16'h0006;
	AST_ACK_AFTER_REQ: assert property ((host_rd || host_wr) |=> host_ack) else $error("ack missing");
	AST_NO_STRAY_ACK: assert property (!(host_rd || host_wr) |=> !host_ack) else $error("stray ack");
	AST_UNMAPPED: assert property (host_rd && !host_wr && host_addr inside {[16'h000A:16'h000C]} |=> host_err_addr)
		else $error("unmapped address accepted");
	AST_FWD_SINGLE: assert property (fwd_run_req |=> !fwd_run_req) else $error("forward pulse too long");
	AST_FWD_CAUSE: assert property (fwd_run_req |-> $past(wr_run && host_wdata[1])) else $error("forward without write");
	AST_FRESET_CAUSE: assert property (fault_reset_req |-> $past(wr_run && host_wdata[3])) else $error("bad fault reset");
	AST_ESTOP_CAUSE: assert property (estop_req |-> $past(wr_run) && $past(host_wdata[4])) else $error("bad estop");
	AST_RAMP_KEEP: assert property (!wr_up |=> $stable(ramp_up_time)) else $error("ramp changed unasked");
	AST_RAMP_LOAD: assert property (wr_up && host_wdata <= 16'hEA60 |=> ramp_up_time == $past(host_wdata))
		else $error("ramp not loaded");
	AST_SETPOINT_RANGE: assert property ($past(resetn) && $past(start_frequency) <= $past(max_frequency)
		|-> frequency_setpoint >= $past(start_frequency) && frequency_setpoint <= $past(max_frequency))
		else $error("setpoint out of range");
	cover property (fwd_run_req);
	cover property (estop_req);
	cover property (host_err_addr);
endmodule // dcp_param_map_props

bind dcp_param_map dcp_param_map_props i_dcp_param_map_props (.clk_sys(clk_sys), .resetn(resetn),
	.host_addr(host_addr), .host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata), .host_ack(host_ack),
	.host_err_addr(host_err_addr), .fwd_run_req(fwd_run_req), .fault_reset_req(fault_reset_req),
	.estop_req(estop_req), .ramp_up_time(ramp_up_time), .start_frequency(start_frequency),
	.max_frequency(max_frequency), .frequency_setpoint(frequency_setpoint));

/* File: dcp_param_regs.vh */
`ifndef DCP_PARAM_REGS_VH
`define DCP_PARAM_REGS_VH

// Word addresses of the common area
`define DCP_ADDR_POWER_RATING    16'h0000
`define DCP_ADDR_SUPPLY_CLASS    16'h0001
`define DCP_ADDR_FW_VERSION      16'h0002
`define DCP_ADDR_PARAM_LOCK      16'h0003
`define DCP_ADDR_FREQ_SETPOINT   16'h0004
`define DCP_ADDR_RUN_CONTROL     16'h0005
`define DCP_ADDR_RAMP_UP         16'h0006
`define DCP_ADDR_RAMP_DOWN       16'h0007
`define DCP_ADDR_OUT_CURRENT     16'h0008
`define DCP_ADDR_OUT_FREQUENCY   16'h0009
`define DCP_ADDR_DRIVE_STATE     16'h000D
`define DCP_ADDR_FAULT_CAUSE     16'h000E
`define DCP_ADDR_INPUT_PINS      16'h000F

// Run control word fields
`define DCP_RUN_STOP_BIT         0
`define DCP_RUN_FWD_BIT          1
`define DCP_RUN_REV_BIT          2
`define DCP_RUN_FRESET_BIT       3
`define DCP_RUN_ESTOP_BIT        4
`define DCP_RUN_CMD_WIDTH        5
`define DCP_RUN_SRC_LSB          6
`define DCP_RUN_SRC_MSB          7
`define DCP_FREQ_SRC_LSB         8
`define DCP_FREQ_SRC_MSB         12

// Run source codes
`define DCP_RUN_SRC_TERMINAL     2'h0
`define DCP_RUN_SRC_KEYPAD       2'h1
`define DCP_RUN_SRC_SERIAL       2'h3

// Frequency source codes
`define DCP_FREQ_SRC_SERIAL      5'h13

// Drive state word fields
`define DCP_STATE_LATCH_FWD_BIT  11
`define DCP_STATE_LATCH_REV_BIT  12

// Fault cause word fields
`define DCP_FAULT_GROUND_BIT     5
`define DCP_FAULT_NV_WRITE_BIT   11
`define DCP_FAULT_UNDERVOLT_BIT  15

// Reset values
`define DCP_RESET_PARAM_LOCK     16'h0000
`define DCP_RESET_RAMP_UP        16'h0032
`define DCP_RESET_RAMP_DOWN      16'h0064
`define DCP_RESET_CMD_BITS       5'h00

// Largest ramp time accepted, 6000.0 s in 0.1 s steps
`define DCP_RAMP_MAX             16'hEA60

// Version code, value arbitrary
`define DCP_FW_VERSION_CODE      16'h0012

`endif
